// File: src/uepmc_pkg.sv
// Constants and types for the endpoint mode and byte-count block.
package uepmc_pkg;
	// ----------------------------------------------------------------
	// Register map and FIFO windows
	// ----------------------------------------------------------------
	localparam logic [7:0] DEV_ADDR_OFS = 8'h10;
	localparam logic [7:0] CTRL_CNT_OFS = 8'h11;
	localparam logic [7:0] CTRL_MODE_OFS = 8'h12;
	localparam logic [7:0] DATA_CNT_OFS = 8'h13;
	localparam logic [7:0] DATA_MODE_OFS = 8'h14;
	localparam logic [7:0] DATA_FIFO_BASE = 8'hF0;
	localparam logic [7:0] CTRL_FIFO_BASE = 8'hF8;
	localparam int FIFO_BYTES = 16;
	localparam int IDX_CTRL_BIT = 3;
	// ----------------------------------------------------------------
	// Field positions, masks and codes
	// ----------------------------------------------------------------
	localparam int SETUP_BIT = 7;
	localparam int IN_BIT = 6;
	localparam int OUT_BIT = 5;
	localparam int ACKED_BIT = 4;
	localparam int STALL_BIT = 7;
	localparam int TOGGLE_BIT = 7;
	localparam int VALID_BIT = 6;
	localparam int ADDR_EN_BIT = 7;
	localparam logic [7:0] DATA_MODE_WMASK = 8'h9F;
	localparam logic [7:0] CNT_WMASK = 8'hCF;
	localparam logic [3:0] MODE_NAK_ALL = 4'h1;
	localparam logic [3:0] MODE_ACK_OUT = 4'hB;
	localparam logic [3:0] MODE_ACK_IN = 4'hF;
	localparam logic [3:0] CRC_BYTES = 4'h2;
	localparam logic [3:0] CTRL_EP = 4'h0;
	localparam logic [3:0] DATA_EP = 4'h1;

	typedef enum logic [1:0] {
		PID_OUT = 2'h0,
		PID_IN = 2'h1,
		PID_SETUP = 2'h2
	} uepmc_pid_type;

	typedef enum logic [1:0] {
		HS_NONE = 2'h0,
		HS_ACK = 2'h1,
		HS_NAK = 2'h2,
		HS_STALL = 2'h3
	} uepmc_hs_type;

	typedef struct packed {
		logic valid;
		logic [6:0] addr;
		logic [3:0] ep;
		uepmc_pid_type pid;
	} uepmc_tok_type;

	typedef struct packed {
		logic valid;
		logic [3:0] ep;
		uepmc_pid_type pid;
		logic acked;
		logic toggle;
		logic data_ok;
		logic [3:0] bytes;
	} uepmc_done_type;

	typedef struct packed {
		logic wr;
		logic [3:0] idx;
		logic [7:0] data;
	} uepmc_fifo_type;

	typedef struct packed {
		logic [7:0] dev_addr;
		logic [7:0] ctrl_cnt;
		logic [7:0] ctrl_mode;
		logic [7:0] data_cnt;
		logic [7:0] data_mode;
		logic [FIFO_BYTES-1:0][7:0] fifo;
		logic mode_lock;
		logic cnt_lock;
		logic setup_force;
		logic [7:0] rdata;
		logic [7:0] eng_rdata;
	} uepmc_state_type;
endpackage : uepmc_pkg

// File: src/uepmc_top.sv
// Endpoint mode, status, byte-count registers and endpoint FIFOs.
`timescale 1ns/1ns
module uepmc_top (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic USB_BUS_RESET,
	input wire logic [7:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [7:0] REG_RDATA,
	input wire uepmc_pkg::uepmc_tok_type TOKEN,
	output uepmc_pkg::uepmc_hs_type HANDSHAKE,
	input wire logic ENG_SETUP_START,
	input wire logic ENG_ACK_START,
	input wire uepmc_pkg::uepmc_done_type ENG_DONE,
	input wire uepmc_pkg::uepmc_fifo_type ENG_FIFO,
	output logic [7:0] ENG_FIFO_RDATA,
	output logic [7:0] CTRL_COUNT,
	output logic [7:0] DATA_COUNT
);
	// ----------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------
	function automatic uepmc_pkg::uepmc_hs_type hs_for(
		input logic [3:0] mode,
		input logic stall,
		input uepmc_pkg::uepmc_pid_type pid
	);
		uepmc_pkg::uepmc_hs_type r;
		r = uepmc_pkg::HS_NONE;
		case (pid)
			uepmc_pkg::PID_SETUP:
			begin
				if (mode == uepmc_pkg::MODE_NAK_ALL ||
					mode == uepmc_pkg::MODE_ACK_OUT ||
					mode == uepmc_pkg::MODE_ACK_IN)
					r = uepmc_pkg::HS_ACK;
			end
			uepmc_pkg::PID_OUT:
			begin
				if (mode == uepmc_pkg::MODE_ACK_OUT)
					r = stall ? uepmc_pkg::HS_STALL : uepmc_pkg::HS_ACK;
				else if (mode == uepmc_pkg::MODE_NAK_ALL ||
					mode == uepmc_pkg::MODE_ACK_IN)
					r = uepmc_pkg::HS_NAK;
			end
			uepmc_pkg::PID_IN:
			begin
				if (mode == uepmc_pkg::MODE_ACK_IN)
					r = stall ? uepmc_pkg::HS_STALL : uepmc_pkg::HS_ACK;
				else if (mode == uepmc_pkg::MODE_NAK_ALL ||
					mode == uepmc_pkg::MODE_ACK_OUT)
					r = uepmc_pkg::HS_NAK;
			end
			default:
			begin
				r = uepmc_pkg::HS_NONE;
			end
		endcase
		return r;
	endfunction : hs_for

	// Mode byte after a finished transaction, shared by both endpoints.
	function automatic logic [7:0] mode_done(
		input logic [7:0] m,
		input uepmc_pkg::uepmc_done_type d
	);
		logic [7:0] r;
		r = m;
		r[uepmc_pkg::ACKED_BIT] = d.acked;
		if (d.acked && d.pid == uepmc_pkg::PID_OUT &&
			m[3:0] == uepmc_pkg::MODE_ACK_OUT)
			r[3:0] = uepmc_pkg::MODE_NAK_ALL;
		return r;
	endfunction : mode_done

	// Count byte after a received OUT or SETUP data packet.
	function automatic logic [7:0] cnt_done(
		input logic [7:0] c,
		input uepmc_pkg::uepmc_done_type d
	);
		logic [7:0] r;
		r = c;
		r[uepmc_pkg::TOGGLE_BIT] = d.toggle;
		r[uepmc_pkg::VALID_BIT] = d.data_ok;
		r[3:0] = d.bytes + uepmc_pkg::CRC_BYTES;
		return r;
	endfunction : cnt_done

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	uepmc_pkg::uepmc_state_type s_reg;
	uepmc_pkg::uepmc_state_type s_next;
	logic [3:0] cpu_idx;
	logic cpu_fifo;
	logic done_ctrl;
	logic done_data;
	logic rx_pid;
	logic addr_hit;

	assign cpu_idx = REG_ADDR[3:0];
	assign cpu_fifo = REG_ADDR >= uepmc_pkg::DATA_FIFO_BASE;
	assign done_ctrl = ENG_DONE.valid && ENG_DONE.ep == uepmc_pkg::CTRL_EP;
	assign done_data = ENG_DONE.valid && ENG_DONE.ep == uepmc_pkg::DATA_EP;
	assign rx_pid = ENG_DONE.pid != uepmc_pkg::PID_IN;
	assign addr_hit = s_reg.dev_addr[uepmc_pkg::ADDR_EN_BIT] &&
		TOKEN.addr == s_reg.dev_addr[6:0];

	// ----------------------------------------------------------------
	// Handshake choice
	// ----------------------------------------------------------------
	always_comb
	begin
		HANDSHAKE = uepmc_pkg::HS_NONE;
		if (TOKEN.valid && addr_hit)
		begin
			if (TOKEN.ep == uepmc_pkg::CTRL_EP)
				HANDSHAKE = hs_for(s_reg.ctrl_mode[3:0], 1'b0, TOKEN.pid);
			else if (TOKEN.ep == uepmc_pkg::DATA_EP)
				HANDSHAKE = hs_for(s_reg.data_mode[3:0],
					s_reg.data_mode[uepmc_pkg::STALL_BIT], TOKEN.pid);
		end
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	// CPU effects are applied first, then engine events, then bus reset, so an engine
	// set or lock in the same cycle as a CPU clear or unlock wins.
	always_comb
	begin
		s_next = s_reg;
		s_next.rdata = 8'h00;
		s_next.eng_rdata = s_reg.fifo[ENG_FIFO.idx];
		if (REG_RD)
		begin
			case (REG_ADDR)
				uepmc_pkg::DEV_ADDR_OFS: s_next.rdata = s_reg.dev_addr;
				uepmc_pkg::CTRL_CNT_OFS:
				begin
					s_next.rdata = s_reg.ctrl_cnt;
					s_next.cnt_lock = 1'b0;
				end
				uepmc_pkg::CTRL_MODE_OFS:
				begin
					s_next.rdata = s_reg.ctrl_mode;
					s_next.mode_lock = 1'b0;
				end
				uepmc_pkg::DATA_CNT_OFS: s_next.rdata = s_reg.data_cnt;
				uepmc_pkg::DATA_MODE_OFS: s_next.rdata = s_reg.data_mode;
				default:
				begin
					if (cpu_fifo)
						s_next.rdata = s_reg.fifo[cpu_idx];
				end
			endcase
		end
		if (REG_WR)
		begin
			case (REG_ADDR)
				uepmc_pkg::DEV_ADDR_OFS: s_next.dev_addr = REG_WDATA;
				uepmc_pkg::CTRL_CNT_OFS:
				begin
					if (!s_reg.cnt_lock)
						s_next.ctrl_cnt = REG_WDATA & uepmc_pkg::CNT_WMASK;
				end
				uepmc_pkg::CTRL_MODE_OFS:
				begin
					if (!s_reg.mode_lock)
						s_next.ctrl_mode = {s_reg.setup_force, 3'h0,
							REG_WDATA[3:0]};
				end
				uepmc_pkg::DATA_CNT_OFS:
					s_next.data_cnt = REG_WDATA & uepmc_pkg::CNT_WMASK;
				uepmc_pkg::DATA_MODE_OFS:
					s_next.data_mode = REG_WDATA & uepmc_pkg::DATA_MODE_WMASK;
				default:
				begin
					if (cpu_fifo && !(cpu_idx[uepmc_pkg::IDX_CTRL_BIT] &&
						s_reg.ctrl_mode[uepmc_pkg::SETUP_BIT]))
						s_next.fifo[cpu_idx] = REG_WDATA;
				end
			endcase
		end
		if (ENG_FIFO.wr)
			s_next.fifo[ENG_FIFO.idx] = ENG_FIFO.data;
		if (ENG_ACK_START)
			s_next.setup_force = 1'b0;
		if (ENG_SETUP_START)
		begin
			s_next.setup_force = 1'b1;
			s_next.ctrl_mode[uepmc_pkg::SETUP_BIT] = 1'b1;
		end
		if (done_ctrl)
		begin
			s_next.ctrl_mode = mode_done(s_next.ctrl_mode, ENG_DONE);
			s_next.mode_lock = 1'b1;
			case (ENG_DONE.pid)
				uepmc_pkg::PID_SETUP:
					s_next.ctrl_mode[uepmc_pkg::SETUP_BIT] = 1'b1;
				uepmc_pkg::PID_IN:
				begin
					if (ENG_DONE.acked)
						s_next.ctrl_mode[uepmc_pkg::IN_BIT] = 1'b1;
				end
				default:
				begin
					if (ENG_DONE.acked)
						s_next.ctrl_mode[uepmc_pkg::OUT_BIT] = 1'b1;
				end
			endcase
			if (rx_pid)
			begin
				s_next.ctrl_cnt = cnt_done(s_reg.ctrl_cnt, ENG_DONE);
				s_next.cnt_lock = 1'b1;
			end
		end
		if (done_data)
		begin
			s_next.data_mode = mode_done(s_next.data_mode, ENG_DONE);
			if (rx_pid)
				s_next.data_cnt = cnt_done(s_reg.data_cnt, ENG_DONE);
		end
		// A bus reset returns the endpoint logic to its power-up state.
		if (USB_BUS_RESET)
			s_next = '0;
	end

	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
			s_reg <= '0;
		else
			s_reg <= s_next;
	end

	assign REG_RDATA = s_reg.rdata;
	assign ENG_FIFO_RDATA = s_reg.eng_rdata;
	assign CTRL_COUNT = s_reg.ctrl_cnt;
	assign DATA_COUNT = s_reg.data_cnt;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RST_N);

	logic quiet;
	assign quiet = !ENG_DONE.valid && !ENG_SETUP_START && !USB_BUS_RESET;

	sequence s_setup_begin;
		ENG_SETUP_START && !USB_BUS_RESET;
	endsequence

	sequence s_ctrl_write;
		REG_WR && REG_ADDR == uepmc_pkg::CTRL_MODE_OFS && quiet;
	endsequence

	chk_mode_lock_hold: assert property (
		s_ctrl_write and s_reg.mode_lock |=>
		s_reg.ctrl_mode == $past(s_reg.ctrl_mode))
		else $error("Locked control mode changed by a write.");

	chk_read_unlock: assert property (
		REG_RD && REG_ADDR == uepmc_pkg::CTRL_MODE_OFS && quiet |=>
		!s_reg.mode_lock && REG_RDATA == $past(s_reg.ctrl_mode))
		else $error("Control mode read did not unlock.");

	chk_status_clear: assert property (
		s_ctrl_write and !s_reg.mode_lock |=>
		s_reg.ctrl_mode[6:4] == 3'h0 &&
		s_reg.ctrl_mode[3:0] == $past(REG_WDATA[3:0]))
		else $error("Unlocked write left status bits set.");

	chk_setup_hold: assert property (
		s_setup_begin ##1 (!ENG_ACK_START && !USB_BUS_RESET)[*2] |->
		s_reg.ctrl_mode[uepmc_pkg::SETUP_BIT] && s_reg.setup_force)
		else $error("Setup flag dropped before acknowledge.");

	chk_fifo_block: assert property (
		REG_WR && cpu_fifo && cpu_idx[uepmc_pkg::IDX_CTRL_BIT] &&
		s_reg.ctrl_mode[uepmc_pkg::SETUP_BIT] && !ENG_FIFO.wr &&
		!USB_BUS_RESET |=> s_reg.fifo[$past(cpu_idx)] ==
		$past(s_reg.fifo[cpu_idx]))
		else $error("Control FIFO written while setup flag set.");

	chk_acked_bit: assert property (
		done_data && !USB_BUS_RESET |=>
		s_reg.data_mode[uepmc_pkg::ACKED_BIT] == $past(ENG_DONE.acked))
		else $error("Acknowledged bit does not follow transaction.");

	chk_auto_nak: assert property (
		done_ctrl && ENG_DONE.acked && ENG_DONE.pid == uepmc_pkg::PID_OUT &&
		s_reg.ctrl_mode[3:0] == uepmc_pkg::MODE_ACK_OUT && !USB_BUS_RESET
		|=> s_reg.ctrl_mode[3:0] == uepmc_pkg::MODE_NAK_ALL &&
		s_reg.ctrl_mode[uepmc_pkg::OUT_BIT])
		else $error("ACK OUT mode did not fall back to NAK.");

	chk_in_flag: assert property (
		done_ctrl && ENG_DONE.acked && ENG_DONE.pid == uepmc_pkg::PID_IN &&
		!USB_BUS_RESET |=> s_reg.ctrl_mode[uepmc_pkg::IN_BIT])
		else $error("Acknowledged IN did not set the in flag.");

	chk_out_flag: assert property (
		done_ctrl && ENG_DONE.acked && ENG_DONE.pid == uepmc_pkg::PID_OUT &&
		!USB_BUS_RESET |=> s_reg.ctrl_mode[uepmc_pkg::OUT_BIT])
		else $error("Acknowledged OUT did not set the out flag.");

	chk_data_nolock: assert property (
		REG_WR && REG_ADDR == uepmc_pkg::DATA_MODE_OFS && !ENG_DONE.valid &&
		!USB_BUS_RESET |=> s_reg.data_mode ==
		($past(REG_WDATA) & uepmc_pkg::DATA_MODE_WMASK))
		else $error("Data endpoint mode write did not land.");

	chk_toggle_copy: assert property (
		done_ctrl && rx_pid && !USB_BUS_RESET |=>
		s_reg.ctrl_cnt[uepmc_pkg::TOGGLE_BIT] == $past(ENG_DONE.toggle) &&
		s_reg.ctrl_cnt[uepmc_pkg::VALID_BIT] == $past(ENG_DONE.data_ok))
		else $error("Received toggle or data status not copied.");

	chk_nak_answer: assert property (
		TOKEN.valid && addr_hit && TOKEN.ep == uepmc_pkg::CTRL_EP &&
		s_reg.ctrl_mode[3:0] == uepmc_pkg::MODE_NAK_ALL |->
		HANDSHAKE == (TOKEN.pid == uepmc_pkg::PID_SETUP ?
		uepmc_pkg::HS_ACK : uepmc_pkg::HS_NAK))
		else $error("NAK mode gave a wrong handshake.");

	chk_stall_answer: assert property (
		TOKEN.valid && addr_hit && TOKEN.ep == uepmc_pkg::DATA_EP &&
		s_reg.data_mode[uepmc_pkg::STALL_BIT] &&
		s_reg.data_mode[3:0] == uepmc_pkg::MODE_ACK_OUT &&
		TOKEN.pid == uepmc_pkg::PID_OUT |-> HANDSHAKE == uepmc_pkg::HS_STALL)
		else $error("Stalled endpoint did not stall OUT.");

	chk_count_crc: assert property (
		done_data && rx_pid && !USB_BUS_RESET |=>
		s_reg.data_cnt[3:0] == $past(ENG_DONE.bytes) + uepmc_pkg::CRC_BYTES)
		else $error("Received count lacks the CRC bytes.");

	chk_count_lock: assert property (
		done_ctrl && rx_pid && !USB_BUS_RESET ##1
		REG_WR && REG_ADDR == uepmc_pkg::CTRL_CNT_OFS && quiet |=>
		s_reg.ctrl_cnt == $past(s_reg.ctrl_cnt))
		else $error("Locked control count was overwritten.");

	chk_addr_gate: assert property (
		TOKEN.valid && !s_reg.dev_addr[uepmc_pkg::ADDR_EN_BIT] |->
		HANDSHAKE == uepmc_pkg::HS_NONE)
		else $error("Handshake given while address disabled.");
endmodule : uepmc_top

// File: tb/test_uepmc_top.sv
// Self-checking bench for the endpoint mode and byte-count block.
`timescale 1ns/1ns
`define CHK(nm, ex, gt) \
	begin \
		comparisons++; \
		if ((gt) !== (ex)) \
		begin \
			n_fail++; \
			$display("[ERR] %s expected %h seen %h", nm, ex, gt); \
		end \
	end
module test_uepmc_top;
	logic clk = 1'h0;
	logic rst_n = 1'h0;
	logic bus_rst = 1'h0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'h0;
	logic reg_rd = 1'h0;
	logic [7:0] reg_rdata;
	logic [7:0] ctrl_count;
	logic [7:0] data_count;
	logic [7:0] eng_rdata;
	uepmc_pkg::uepmc_tok_type token;
	uepmc_pkg::uepmc_hs_type handshake;
	uepmc_pkg::uepmc_done_type done;
	uepmc_pkg::uepmc_fifo_type fifo;
	logic setup_start;
	logic ack_start;
	int n_fail = 0;
	int comparisons = 0;
	int cycles = 0;

	always #50 clk = ~clk;

	uepmc_top uepmc_top_i (.CLK(clk), .RST_N(rst_n), .USB_BUS_RESET(bus_rst),
		.REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr),
		.REG_RD(reg_rd), .REG_RDATA(reg_rdata), .TOKEN(token),
		.HANDSHAKE(handshake), .ENG_SETUP_START(setup_start),
		.ENG_ACK_START(ack_start), .ENG_DONE(done), .ENG_FIFO(fifo),
		.ENG_FIFO_RDATA(eng_rdata), .CTRL_COUNT(ctrl_count),
		.DATA_COUNT(data_count));

	uepmc_host uepmc_host_i (.clk(clk), .token(token),
		.handshake(handshake), .setup_start(setup_start),
		.ack_start(ack_start), .done(done), .fifo(fifo));

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : report_and_stop

	// A hung handshake would otherwise stall the run for good.
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			n_fail++;
			report_and_stop();
		end
	end

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1'h1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'h0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] e, string nm);
		@(posedge clk);
		reg_rd <= 1'h1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'h0;
		@(negedge clk);
		`CHK(nm, e, reg_rdata)
	endtask : rd

	task automatic tok(input logic [3:0] ep, input logic [1:0] p,
		input logic [1:0] e, input logic [6:0] a = 7'h05);
		logic [1:0] h;
		uepmc_host_i.send(a, ep, p, h);
		`CHK("handshake", e, h)
	endtask : tok

	initial
	begin
		repeat (6) @(posedge clk);
		rst_n <= 1'h1;
		for (int i = 0; i < 4; i++)
			rd(8'h11 + 8'(i), 8'h00, "reset");
		tok(4'h0, 2'h2, 2'h0);
		wr(8'h10, 8'h85);
		wr(8'h12, 8'hFB);
		tok(4'h0, 2'h0, 2'h0, 7'h06);
		rd(8'h12, 8'h0B, "ctl mode");
		tok(4'h0, 2'h0, 2'h1);
		tok(4'h0, 2'h1, 2'h2);
		uepmc_host_i.finish(4'h0, 2'h0, 1'h1, 1'h1, 1'h1, 4'h3);
		wr(8'h11, 8'h00);
		wr(8'h12, 8'h0F);
		@(negedge clk);
		`CHK("ctl count port", 8'hC5, ctrl_count)
		rd(8'h12, 8'h31, "ctl mode");
		rd(8'h11, 8'hC5, "ctl count");
		wr(8'h12, 8'h01);
		rd(8'h12, 8'h01, "ctl mode");
		for (int p = 0; p < 3; p++)
			tok(4'h0, 2'(p), (p == 2) ? 2'h1 : 2'h2);
		// Setup window: CPU FIFO writes and flag clears must not land.
		uepmc_host_i.pulse(1'h0);
		wr(8'hF8, 8'hAA);
		uepmc_host_i.put(4'h8, 8'h11);
		wr(8'h12, 8'h01);
		rd(8'h12, 8'h81, "setup flag");
		rd(8'hF8, 8'h11, "ctl fifo");
		uepmc_host_i.pulse(1'h1);
		uepmc_host_i.finish(4'h0, 2'h2, 1'h1, 1'h0, 1'h1, 4'h8);
		rd(8'h12, 8'h91, "ctl mode");
		rd(8'h11, 8'h4A, "ctl count");
		wr(8'h12, 8'h01);
		wr(8'hF8, 8'hAA);
		rd(8'hF8, 8'hAA, "ctl fifo");
		uepmc_host_i.finish(4'h0, 2'h1, 1'h1, 1'h0, 1'h0, 4'h0);
		rd(8'h12, 8'h51, "ctl mode");
		uepmc_host_i.finish(4'h0, 2'h0, 1'h0, 1'h0, 1'h0, 4'h0);
		rd(8'h12, 8'h41, "ctl mode");
		rd(8'h11, 8'h02, "ctl count");
		wr(8'h14, 8'h8B);
		tok(4'h1, 2'h0, 2'h3);
		wr(8'h14, 8'h0B);
		tok(4'h1, 2'h0, 2'h1);
		tok(4'h1, 2'h1, 2'h2);
		uepmc_host_i.finish(4'h1, 2'h0, 1'h1, 1'h1, 1'h0, 4'h0);
		rd(8'h14, 8'h11, "data mode");
		rd(8'h13, 8'h82, "data count");
		uepmc_host_i.finish(4'h1, 2'h0, 1'h0, 1'h0, 1'h0, 4'h1);
		wr(8'h14, 8'h8F);
		rd(8'h14, 8'h8F, "data mode");
		tok(4'h1, 2'h1, 2'h3);
		wr(8'h13, 8'h88);
		rd(8'h13, 8'h88, "data count");
		@(negedge clk);
		`CHK("data count port", 8'h88, data_count)
		wr(8'hF3, 8'h5A);
		rd(8'hF3, 8'h5A, "data fifo");
		uepmc_host_i.look(4'h3);
		@(negedge clk);
		`CHK("engine fifo", 8'h5A, eng_rdata)
		rd(8'h20, 8'h00, "unmapped");
		@(posedge clk);
		bus_rst <= 1'h1;
		@(posedge clk);
		bus_rst <= 1'h0;
		rd(8'h14, 8'h00, "bus reset");
		// A lock left over from before a hard reset must not survive it.
		uepmc_host_i.finish(4'h0, 2'h0, 1'h1, 1'h0, 1'h1, 4'h1);
		@(posedge clk);
		rst_n <= 1'h0;
		repeat (2) @(posedge clk);
		rst_n <= 1'h1;
		wr(8'h12, 8'h02);
		rd(8'h12, 8'h02, "ctl mode");
		report_and_stop();
	end
endmodule : test_uepmc_top

// File: tb/uepmc_host.sv
// Behavioural serial engine and host driving the engine side ports.
`timescale 1ns/1ns
module uepmc_host (
	input wire logic clk,
	output uepmc_pkg::uepmc_tok_type token,
	input wire uepmc_pkg::uepmc_hs_type handshake,
	output logic setup_start,
	output logic ack_start,
	output uepmc_pkg::uepmc_done_type done,
	output uepmc_pkg::uepmc_fifo_type fifo
);
	initial
	begin
		token = '0;
		setup_start = 1'h0;
		ack_start = 1'h0;
		done = '0;
		fifo = '0;
	end

	// The answer is combinational, so it is taken mid-cycle.
	task automatic send(input logic [6:0] a, input logic [3:0] ep,
		input logic [1:0] p, output logic [1:0] hs);
		@(posedge clk);
		token <= '{1'h1, a, ep, uepmc_pkg::uepmc_pid_type'(p)};
		@(negedge clk);
		hs = handshake;
		@(posedge clk);
		token <= '{1'h0, ~a, ~ep, uepmc_pkg::uepmc_pid_type'(p)};
	endtask : send

	task automatic pulse(input logic ack);
		@(posedge clk);
		setup_start <= ~ack;
		ack_start <= ack;
		@(posedge clk);
		setup_start <= 1'h0;
		ack_start <= 1'h0;
	endtask : pulse

	// The received toggle and data status are handed over as seen.
	task automatic finish(input logic [3:0] ep, input logic [1:0] p,
		input logic ak, input logic tg, input logic ok, input logic [3:0] n);
		@(posedge clk);
		done <= '{1'h1, ep, uepmc_pkg::uepmc_pid_type'(p),
			ak, tg, ok, n};
		@(posedge clk);
		done.valid <= 1'h0;
	endtask : finish

	task automatic put(input logic [3:0] i, input logic [7:0] d);
		@(posedge clk);
		fifo <= '{1'h1, i, d};
		@(posedge clk);
		fifo <= '{1'h0, ~i, ~d};
	endtask : put

	// Parks the engine read index so the FIFO read port can be checked.
	task automatic look(input logic [3:0] i);
		@(posedge clk);
		fifo <= '{1'h0, i, 8'h00};
		@(posedge clk);
	endtask : look
endmodule : uepmc_host
